// *** design/mpu_defs.svh ***
// timing, window and register map constants for the monitor poll/unload block
`ifndef MPU_DEFS_SVH
`define MPU_DEFS_SVH

`define MPU_CLK_MHZ        100
`define MPU_T_POLL_A       16'd48400
`define MPU_T_POLL_B       16'd49400
`define MPU_POLL_PULSE_US  20
`define MPU_POLL_PULSE_CYC (`MPU_POLL_PULSE_US * `MPU_CLK_MHZ)
`define MPU_PSEUDO_NS      100
`define MPU_PSEUDO_CYC     ((`MPU_PSEUDO_NS * `MPU_CLK_MHZ) / 1000)
`define MPU_T_ZERO         16'd0
`define MPU_T_LOADWIN_LO   16'd24000
`define MPU_T_LOADWIN_HI   16'd48000
`define MPU_T_UNLOAD_HI    16'd24000
`define MPU_T_OE_LO        16'd1000
`define MPU_T_OE_HI        16'd24000
`define MPU_DIV_5M         (`MPU_CLK_MHZ / 5)
`define MPU_DIV_2M         (`MPU_CLK_MHZ / 2)
`define MPU_DIV_200K       (`MPU_CLK_MHZ * 5)
`define MPU_SAMP_PRESET    6'd1
`define MPU_SAMP_LAST      6'd37
`define MPU_SAMP_MID       6'd32
`define MPU_LOAD_PRESET    9'd151
`define MPU_LOAD_END       9'd256
`define MPU_DLY_MAX_NS     250
`define MPU_DLY_MAX_CYC    ((`MPU_DLY_MAX_NS * `MPU_CLK_MHZ) / 1000)

// register byte addresses
`define MPU_REG_CTRL       8'h00
`define MPU_REG_STATUS     8'h04
`define MPU_REG_DELAY      8'h08
`define MPU_REG_COUNT      8'h0c
// ctrl fields
`define MPU_CTRL_POLL_EN   0
`define MPU_CTRL_UNLD_EN   1
`define MPU_CTRL_RESET     32'h0000_0003
`define MPU_DELAY_RESET    5'h05
// ahb codes
`define MPU_HTRANS_NONSEQ  2'h2
`define MPU_HTRANS_SEQ     2'h3

`endif

// *** design/mpu_pkg.sv ***
// types shared by the monitor poll/unload block
package mpu_pkg;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_LOAD,
        TX_SHIFT
    } mpu_tx_state_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } mpu_ahb_req_t;

    typedef struct packed {
        logic tx_busy;
        logic permit;
        logic load_flag;
        logic unload_flag;
    } mpu_status_t;

endpackage : mpu_pkg

// *** design/mpu_monitor_poll_unload.sv ***
// data set polling, monitor message capture, memory and controller unload
// Notes on behaviour
// RQ1: 20 us poll-load pulse at 48400, 49400.
// RQ2: shift poll character out low-true at 200 kHz.
// RQ3: leading zero bit precedes poll character.
// RQ4: data set answers within 50/250 us.
// RQ5: invert monitor input, resync on every edge.
// RQ6: 5 MHz sampling counter, preset 1, modulo 37.
// RQ7: count 32 shifts bit into start detector.
// RQ8: start seen: load from 151 until 256.
// RQ9: accept input only while permit flag set.
// RQ10: memory is a serial shift chain.
// RQ11: messages leave memory in fixed stored order.
// RQ12: cycle zero pseudo poll sets unload, positions.
// RQ13: stop shifting when start reaches output.
// RQ14: 2 MHz unload clock phased to poll edges.
// RQ15: controller polls each buffer, 59 us each.
// RQ16: controller poll unloads one waiting message.
// RQ17: unload flag held reset outside 0-24000.
// RQ18: output driver enabled only 1k-24k.
// RQ19: output register clock delayed, up to 250 ns.
// RQ20: unload flag inhibits command edge phasing.
// RQ21: memory shifts on falling edge of clock.
// RQ22: poll and start characters are parameters.
`timescale 1ns/1ps
`include "mpu_defs.svh"

module mpu_monitor_poll_unload #(
    parameter int          POLL_W     = 8,
    parameter logic [7:0]  POLL_CHAR  = 8'ha5,
    parameter int          START_W    = 8,
    parameter logic [7:0]  START_CHAR = 8'h7e,
    parameter int          MEM_BITS   = 512
) (
    // clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_SYS_RST,
    // ahb-lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic [31:0]      O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    // system timing
    input  wire logic [15:0] I_CYCLE_US,
    input  wire logic        I_T50P8,
    // central data set
    output logic             O_DS_CMD_N,
    input  wire logic        I_DS_MON_N,
    // serial line controller
    input  wire logic        I_SLC_POLL,
    input  wire logic        I_SLC_EDGE,
    output logic             O_SLC_MON,
    output logic             O_SLC_MON_OE,
    output logic             O_GOSSIP_INH
);

    localparam int DLY_MAX = `MPU_DLY_MAX_CYC;

    initial begin
        if (POLL_W < 1 || POLL_W > 8 || START_W < 2 || START_W > 8)
            $error("character widths must be 1..8 and 2..8");
        if (MEM_BITS < 2 * START_W)
            $error("memory too short");
        if (DLY_MAX >= `MPU_DIV_2M)
            $error("output delay must be shorter than unload period");
    end

    // ---------------- derived clock strobes ----------------
    logic [4:0]  div5_r;
    logic [5:0]  div2_r;
    logic [8:0]  div200_r;
    wire         tick5    = (div5_r == 5'((`MPU_DIV_5M) - 1));
    wire         tick2    = (div2_r == 6'((`MPU_DIV_2M) - 1));
    wire         tick200  = (div200_r == 9'((`MPU_DIV_200K) - 1));
    logic        unload_r;
    logic        slc_edge_r;
    wire         phase2   = slc_edge_r & ~unload_r;  // RQ14 RQ20

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            div5_r   <= '0;
            div2_r   <= '0;
            div200_r <= '0;
            slc_edge_r <= 1'b0;
        end else begin
            div5_r   <= tick5 ? '0 : div5_r + 5'd1;
            div2_r   <= (tick2 | phase2) ? '0 : div2_r + 6'd1;  // RQ14
            div200_r <= tick200 ? '0 : div200_r + 9'd1;
            slc_edge_r <= I_SLC_EDGE;
        end
    end

    // ---------------- registers over ahb ----------------
    logic [31:0]          ctrl_r;
    logic [4:0]           delay_r;
    logic [15:0]          msg_count_r;
    mpu_pkg::mpu_ahb_req_t req_r;
    mpu_pkg::mpu_status_t  stat;
    logic                 load_r;
    logic                 permit_r;
    mpu_pkg::mpu_tx_state_t tx_state_r;

    wire addr_phase = I_HSEL & I_HREADY &
                      (I_HTRANS == `MPU_HTRANS_NONSEQ || I_HTRANS == `MPU_HTRANS_SEQ);
    wire [7:0] a    = I_HADDR[7:0];
    wire hit_ctrl   = (a == `MPU_REG_CTRL);
    wire hit_stat   = (a == `MPU_REG_STATUS);
    wire hit_dly    = (a == `MPU_REG_DELAY);
    wire hit_cnt    = (a == `MPU_REG_COUNT);
    wire wr_ctrl    = req_r.valid & req_r.write & (req_r.addr == `MPU_REG_CTRL);
    wire wr_dly     = req_r.valid & req_r.write & (req_r.addr == `MPU_REG_DELAY);
    wire poll_en    = ctrl_r[`MPU_CTRL_POLL_EN];
    wire unld_en    = ctrl_r[`MPU_CTRL_UNLD_EN];

    assign stat.tx_busy     = (tx_state_r != mpu_pkg::TX_IDLE);
    assign stat.permit      = permit_r;
    assign stat.load_flag   = load_r;
    assign stat.unload_flag = unload_r;

    // unmapped addresses read zero and ignore writes
    wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                         hit_stat ? {28'h0, stat} :
                         hit_dly  ? {27'h0, delay_r} :
                         hit_cnt  ? {16'h0, msg_count_r} : 32'h0;

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            req_r       <= '0;
            ctrl_r      <= `MPU_CTRL_RESET;
            delay_r     <= `MPU_DELAY_RESET;
            O_HRDATA    <= '0;
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
        end else begin
            req_r.valid <= addr_phase;
            req_r.write <= I_HWRITE;
            req_r.addr  <= a;
            if (addr_phase & ~I_HWRITE)
                O_HRDATA <= rd_mux;
            if (wr_ctrl)
                ctrl_r <= {30'h0, I_HWDATA[1:0]};
            if (wr_dly)  // RQ19
                delay_r <= (I_HWDATA[4:0] > 5'(DLY_MAX)) ? 5'(DLY_MAX) : I_HWDATA[4:0];
        end
    end

    // ---------------- poll character transmit ----------------
    wire at_poll = poll_en & (I_CYCLE_US == `MPU_T_POLL_A || I_CYCLE_US == `MPU_T_POLL_B);
    logic [15:0] cyc_prev_r;
    wire         poll_start = at_poll & (cyc_prev_r != I_CYCLE_US);
    logic [11:0] pulse_cnt_r;
    logic [POLL_W:0] tx_sr_r;
    logic [3:0]  tx_bits_r;

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            cyc_prev_r  <= '0;
            tx_state_r  <= mpu_pkg::TX_IDLE;
            pulse_cnt_r <= '0;
            tx_sr_r     <= '0;
            tx_bits_r   <= '0;
            O_DS_CMD_N  <= 1'b1;
        end else begin
            cyc_prev_r <= I_CYCLE_US;
            case (tx_state_r)
                mpu_pkg::TX_IDLE: begin
                    O_DS_CMD_N <= 1'b1;
                    if (poll_start) begin  // RQ1
                        tx_state_r  <= mpu_pkg::TX_LOAD;
                        pulse_cnt_r <= 12'((`MPU_POLL_PULSE_CYC) - 1);
                        tx_sr_r     <= {1'b0, POLL_CHAR[POLL_W-1:0]};  // RQ3 RQ22
                    end
                end
                mpu_pkg::TX_LOAD: begin
                    if (pulse_cnt_r == 12'h0) begin
                        tx_state_r <= mpu_pkg::TX_SHIFT;
                        tx_bits_r  <= 4'(POLL_W + 1);
                    end else
                        pulse_cnt_r <= pulse_cnt_r - 12'h1;
                end
                mpu_pkg::TX_SHIFT: begin
                    if (tick200) begin  // RQ2
                        if (tx_bits_r == 4'h0) begin
                            tx_state_r <= mpu_pkg::TX_IDLE;
                            O_DS_CMD_N <= 1'b1;
                        end else begin
                            O_DS_CMD_N <= ~tx_sr_r[POLL_W];
                            tx_sr_r    <= {tx_sr_r[POLL_W-1:0], 1'b0};
                            tx_bits_r  <= tx_bits_r - 4'h1;
                        end
                    end
                end
                default: tx_state_r <= mpu_pkg::TX_IDLE;
            endcase
        end
    end

    // ---------------- monitor message receive ----------------
    // input already synchronous; inversion removes the low-true sense
    wire         rx_bit_now = ~I_DS_MON_N;  // RQ5
    logic        rx_prev_r;
    logic [5:0]  samp_r;
    logic [START_W-1:0] det_r;
    logic [8:0]  load_cnt_r;
    wire         in_win    = (I_CYCLE_US >= `MPU_T_LOADWIN_LO) && (I_CYCLE_US < `MPU_T_LOADWIN_HI);
    logic        in_win_r;
    wire         win_trail = in_win_r & ~in_win;
    wire         rx_edge   = rx_bit_now ^ rx_prev_r;  // RQ5
    wire         rx_shift  = permit_r & tick5 & (samp_r == `MPU_SAMP_MID);  // RQ7 RQ9
    wire [START_W-1:0] det_nxt = {det_r[START_W-2:0], rx_prev_r};
    wire         start_rx  = rx_shift & ~load_r & (det_nxt == START_CHAR[START_W-1:0]);  // RQ8 RQ22
    wire         load_done = load_r & rx_shift & (load_cnt_r == 9'(`MPU_LOAD_END - 1));

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            rx_prev_r  <= 1'b0;
            samp_r     <= `MPU_SAMP_PRESET;
            det_r      <= '0;
            load_r     <= 1'b0;
            load_cnt_r <= '0;
            permit_r   <= 1'b0;
            in_win_r   <= 1'b0;
            msg_count_r <= '0;
        end else begin
            rx_prev_r <= rx_bit_now;
            in_win_r  <= in_win;
            // the trailing edge of the load window wins over the clearing term
            if (win_trail)  // RQ9
                permit_r <= 1'b1;
            else if (I_T50P8)
                permit_r <= 1'b0;
            if (rx_edge)  // RQ6
                samp_r <= `MPU_SAMP_PRESET;
            else if (tick5)
                samp_r <= (samp_r == `MPU_SAMP_LAST) ? `MPU_SAMP_PRESET : samp_r + 6'd1;
            if (rx_shift)
                det_r <= det_nxt;
            if (start_rx) begin  // RQ8
                load_r     <= 1'b1;
                load_cnt_r <= `MPU_LOAD_PRESET;
                msg_count_r <= msg_count_r + 16'h1;
            end else if (load_done)
                load_r <= 1'b0;
            else if (load_r & rx_shift)
                load_cnt_r <= load_cnt_r + 9'd1;
        end
    end

    // ---------------- serial monitor memory ----------------
    // one long chain keeps stored messages in arrival order
    logic [MEM_BITS-1:0] mem_r;
    logic        mem_clk_r;
    wire         mem_req   = (load_r & rx_shift) | (unload_r & tick2);
    wire         mem_fall  = mem_clk_r;  // RQ21
    logic        mem_din_r;
    logic [4:0]  dcnt_r;
    wire         out_clk   = (dcnt_r == 5'h1);  // RQ19
    logic [START_W-1:0] out_r;
    logic [9:0]  since_r;

    // clock held high one cycle, data taken as it falls
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            mem_clk_r <= 1'b0;
            mem_din_r <= 1'b0;
            mem_r     <= '0;
            dcnt_r    <= '0;
            out_r     <= '0;
        end else begin
            mem_clk_r <= mem_req;
            if (mem_req)
                mem_din_r <= load_r ? rx_prev_r : mem_r[MEM_BITS-1];  // RQ10
            if (mem_fall)  // RQ21 RQ10 RQ11
                mem_r <= {mem_r[MEM_BITS-2:0], mem_din_r};
            if (mem_fall)  // RQ19
                dcnt_r <= delay_r + 5'h1;
            else if (dcnt_r != 5'h0)
                dcnt_r <= dcnt_r - 5'h1;
            if (out_clk)
                out_r <= {out_r[START_W-2:0], mem_r[MEM_BITS-1]};
        end
    end

    // ---------------- unload control ----------------
    wire in_unld   = (I_CYCLE_US < `MPU_T_UNLOAD_HI);
    wire in_oe     = (I_CYCLE_US >= `MPU_T_OE_LO) && (I_CYCLE_US < `MPU_T_OE_HI);
    logic [3:0] pseudo_r;
    logic       was_zero_r;
    wire        pseudo_go = (I_CYCLE_US == `MPU_T_ZERO) & ~was_zero_r;
    wire        pseudo    = (pseudo_r != 4'h0);  // RQ12
    wire        unld_set  = unld_en & (pseudo | I_SLC_POLL);  // RQ12 RQ16
    // a start still sitting at the output from the last stop must not end the new unload
    wire        start_out = out_clk & ({out_r[START_W-2:0], mem_r[MEM_BITS-1]} == START_CHAR[START_W-1:0]) &
                            (since_r >= 10'(START_W - 1));  // RQ13 RQ16

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            pseudo_r   <= '0;
            was_zero_r <= 1'b0;
            unload_r   <= 1'b0;
            since_r    <= '0;
        end else begin
            was_zero_r <= (I_CYCLE_US == `MPU_T_ZERO);
            if (pseudo_go)
                pseudo_r <= 4'(`MPU_PSEUDO_CYC);
            else if (pseudo)
                pseudo_r <= pseudo_r - 4'h1;
            if (~in_unld)  // RQ17
                unload_r <= 1'b0;
            else if (unld_set) begin
                if (~unload_r)
                    since_r <= '0;
                unload_r <= 1'b1;
            end else if (start_out & unload_r)  // RQ13
                unload_r <= 1'b0;
            if (out_clk && since_r != 10'h3ff && ~unld_set)
                since_r <= since_r + 10'h1;
        end
    end

    // ---------------- controller outputs ----------------
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            O_SLC_MON    <= 1'b0;
            O_SLC_MON_OE <= 1'b0;
            O_GOSSIP_INH <= 1'b0;
        end else begin
            O_SLC_MON_OE <= in_oe;  // RQ18
            O_SLC_MON    <= in_oe & unload_r & out_r[START_W-1];  // RQ16
            O_GOSSIP_INH <= unload_r;  // RQ20
        end
    end

endmodule : mpu_monitor_poll_unload

// *** tb/mpu_monitor.sv ***
// port checker for the monitor poll/unload block
`timescale 1ns/1ps

module mpu_monitor (
    // clock and reset
    input wire logic        I_MCLK,
    input wire logic        I_SYS_RST,
    // watched ports
    input wire logic [15:0] I_CYCLE_US,
    input wire logic        O_HREADYOUT,
    input wire logic        O_HRESP,
    input wire logic        O_DS_CMD_N,
    input wire logic        O_SLC_MON,
    input wire logic        O_SLC_MON_OE,
    input wire logic        O_GOSSIP_INH
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);

    logic [15:0] cyc_r;
    logic [12:0] since_r;
    logic        poll_w;
    logic        oe_w;
    logic        out_w;

    // a poll time seen while busy would restart this count
    assign poll_w = (I_CYCLE_US == 16'hbd10 || I_CYCLE_US == 16'hc108) && cyc_r != I_CYCLE_US;
    assign oe_w   = I_CYCLE_US >= 16'h03e8 && I_CYCLE_US < 16'h5dc0;
    assign out_w  = I_CYCLE_US >= 16'h5dc0;

    always_ff @(posedge I_MCLK) begin
        cyc_r <= I_CYCLE_US;
        if (I_SYS_RST) since_r <= 13'h1fff;
        else if (poll_w) since_r <= 13'h0;
        else if (since_r != 13'h1fff) since_r <= since_r + 13'h1;
    end

    sequence s_out2;
        out_w [*2];
    endsequence
    sequence s_still3;
        !O_GOSSIP_INH [*3];
    endsequence
    property p_oe;
        1'b1 |=> O_SLC_MON_OE == $past(oe_w);
    endproperty
    property p_mon_off;
        !oe_w |=> !O_SLC_MON;
    endproperty
    property p_gos_out;
        s_out2 |=> !O_GOSSIP_INH;
    endproperty
    property p_gos_rise;
        $rose(O_GOSSIP_INH) |-> $past(I_CYCLE_US, 2) < 16'h5dc0;
    endproperty
    property p_quiet;
        s_still3 |-> !O_SLC_MON;
    endproperty
    property p_lead;
        since_r < 13'h09c4 |-> O_DS_CMD_N;
    endproperty
    property p_idle;
        since_r > 13'h1bbc |-> O_DS_CMD_N;
    endproperty
    property p_bus;
        O_HREADYOUT && !O_HRESP;
    endproperty

    a_oe: assert property (p_oe) else $error("enable off window");
    a_mon_off: assert property (p_mon_off) else $error("data off window");
    a_gos_out: assert property (p_gos_out) else $error("unload outside");
    a_gos_rise: assert property (p_gos_rise) else $error("unload set outside");
    a_quiet: assert property (p_quiet) else $error("data while idle");
    a_lead: assert property (p_lead) else $error("early poll bit");
    a_idle: assert property (p_idle) else $error("line not idle");
    a_bus: assert property (p_bus) else $error("bus answer");
endmodule : mpu_monitor

bind mpu_monitor_poll_unload mpu_monitor i_mpu_monitor (
    .I_MCLK       (I_MCLK),
    .I_SYS_RST    (I_SYS_RST),
    .I_CYCLE_US   (I_CYCLE_US),
    .O_HREADYOUT  (O_HREADYOUT),
    .O_HRESP      (O_HRESP),
    .O_DS_CMD_N   (O_DS_CMD_N),
    .O_SLC_MON    (O_SLC_MON),
    .O_SLC_MON_OE (O_SLC_MON_OE),
    .O_GOSSIP_INH (O_GOSSIP_INH)
);

// *** tb/mpu_dataset_model.sv ***
// behavioural data set answering a poll character
`timescale 1ns/1ps

module mpu_dataset_model #(
    parameter int          BIT_CYC  = 740,
    parameter int          RESP_CYC = 3000,
    parameter logic [11:0] MSG      = 12'h7e9
) (
    // clock
    input  wire logic i_mclk,
    // data set lines, low true
    input  wire logic i_cmd_n,
    output logic      o_mon_n
);
    // msb first, low line means one
    initial begin
        o_mon_n = 1'b1;
        forever begin
            @(negedge i_cmd_n);
            repeat (RESP_CYC) @(posedge i_mclk);
            for (int k = 11; k >= 0; k--) begin
                o_mon_n <= ~MSG[k];
                repeat (BIT_CYC) @(posedge i_mclk);
            end
            o_mon_n <= 1'b1;
        end
    end
endmodule : mpu_dataset_model

// *** tb/tb_monitor_poll_unload.sv ***
// bench for the monitor poll/unload block
`timescale 1ns/1ps
`include "mpu_defs.svh"

module tb_monitor_poll_unload;
    localparam logic [7:0] PCH = 8'ha5;
    localparam logic [7:0] SCH = 8'h7e;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } mpu_row_t;

    logic        mclk   = 1'b0;
    logic        rst    = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] cyc    = 16'h0;
    logic [2:0]  pl     = 3'h0;
    logic [31:0] hrdata;
    logic        hrdy;
    logic        hresp;
    logic        cmd_n;
    logic        mon_n;
    logic        smon;
    logic        soe;
    logic        gos;
    logic [31:0] q;
    int          n;
    int          error_cnt = 0;
    int          checks    = 0;
    // write first when w is set, then read back
    mpu_row_t    rows [6]  = '{
        '{1'b0, `MPU_REG_CTRL, 32'h0, `MPU_CTRL_RESET},
        '{1'b0, `MPU_REG_DELAY, 32'h0, {27'h0, `MPU_DELAY_RESET}},
        '{1'b1, `MPU_REG_DELAY, 32'h1e, 32'h19},
        '{1'b1, `MPU_REG_DELAY, 32'h07, 32'h07},
        '{1'b1, 8'h10, 32'hffff_ffff, 32'h0},
        '{1'b1, `MPU_REG_COUNT, 32'h1234, 32'h0}};

    mpu_monitor_poll_unload #(
        .POLL_CHAR  (PCH),
        .START_CHAR (SCH)
    ) i_mpu_monitor_poll_unload (
        .I_MCLK       (mclk),
        .I_SYS_RST    (rst),
        .I_HSEL       (hsel),
        .I_HADDR      (haddr),
        .I_HTRANS     (htrans),
        .I_HWRITE     (hwrite),
        .I_HSIZE      (3'h2),
        .I_HWDATA     (hwdata),
        .I_HREADY     (hrdy),
        .O_HRDATA     (hrdata),
        .O_HREADYOUT  (hrdy),
        .O_HRESP      (hresp),
        .I_CYCLE_US   (cyc),
        .I_T50P8      (pl[2]),
        .O_DS_CMD_N   (cmd_n),
        .I_DS_MON_N   (mon_n),
        .I_SLC_POLL   (pl[0]),
        .I_SLC_EDGE   (pl[1]),
        .O_SLC_MON    (smon),
        .O_SLC_MON_OE (soe),
        .O_GOSSIP_INH (gos)
    );

    mpu_dataset_model #(
        .MSG ({SCH, 4'h9})
    ) i_mpu_dataset_model (
        .i_mclk  (mclk),
        .i_cmd_n (cmd_n),
        .o_mon_n (mon_n)
    );

    always #5 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic wt(input int c);
        repeat (c) @(posedge mclk);
    endtask : wt

    task automatic setc(input logic [15:0] v);
        @(posedge mclk);
        cyc <= v;
    endtask : setc

    task automatic pls(input logic [2:0] m);
        @(posedge mclk);
        pl <= m;
        @(posedge mclk);
        pl <= 3'h0;
    endtask : pls

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= `MPU_HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge mclk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask : ahb

    task automatic st;
        ahb(1'b0, `MPU_REG_STATUS, 32'h0, q);
    endtask : st

    task automatic do_rst;
        @(posedge mclk);
        rst <= 1'b1;
        wt(4);
        chk(hrdata, 32'h0);
        chk({26'h0, hrdy, hresp, cmd_n, smon, soe, gos}, 32'h28);
        rst <= 1'b0;
    endtask : do_rst

    // bounded so a silent line cannot hang the run
    initial begin
        repeat (90000) @(posedge mclk);
        error_cnt++;
        stop_test;
    end

    initial begin
        do_rst;
        foreach (rows[i]) begin
            if (rows[i].w) ahb(1'b1, rows[i].a, rows[i].d, q);
            ahb(1'b0, rows[i].a, 32'h0, q);
            chk(q, rows[i].e);
        end
        setc(16'h5dc0);
        setc(16'hbb80);
        st;
        chk(q & 32'h4, 32'h4);
        setc(16'hbd10);
        n = 0;
        while (cmd_n !== 1'b0 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        chk(32'(n > 2400 && n < 3010), 32'h1);
        wt(250);
        for (int k = 7; k >= 0; k--) begin
            chk(32'(cmd_n), {31'h0, ~PCH[k]});
            wt(500);
        end
        chk(32'(cmd_n), 32'h1);
        wt(14000);
        st;
        chk(q & 32'ha, 32'h2);
        ahb(1'b0, `MPU_REG_COUNT, 32'h0, q);
        chk(q, 32'h1);
        pls(3'h4);
        st;
        chk(q & 32'h4, 32'h0);
        // park away from poll times so reset cannot start one
        setc(16'h03e8);
        do_rst;
        setc(16'hbd10);
        wt(20000);
        st;
        chk(q & 32'h2, 32'h0);
        setc(16'h01f4);
        wt(2);
        chk(32'(soe), 32'h0);
        pls(3'h1);
        wt(3);
        chk(32'(gos), 32'h1);
        pls(3'h2);
        st;
        chk(q & 32'h1, 32'h1);
        setc(16'h03e8);
        wt(2);
        chk(32'(soe), 32'h1);
        setc(16'h5dc0);
        wt(3);
        chk({30'h0, soe, gos}, 32'h0);
        setc(16'h0000);
        wt(4);
        chk(32'(gos), 32'h1);
        ahb(1'b1, `MPU_REG_CTRL, 32'h1, q);
        setc(16'h5dc0);
        setc(16'h01f4);
        pls(3'h1);
        wt(3);
        chk(32'(gos), 32'h0);
        stop_test;
    end
endmodule : tb_monitor_poll_unload
